//--- inc/fcic_pkg.sv
// shared constants for the flash command interface host controller
// assumes a 100 MHz system clock and a byte-wide flash with 19 address bits
package fcic_pkg;
	// ==========================================================
	// widths
	localparam int FCIC_AW = 19; // address bits 18..0
	localparam int FCIC_DW = 8; // data lines 7..0
	// ==========================================================
	// timing, in ns, and derived counts at clk_sys
	localparam int FCIC_CLK_MHZ = 100; // clk_sys rate
	localparam int FCIC_T_SETUP_NS = 10; // address/data before strobe
	localparam int FCIC_T_READ_NS = 70; // output gate low to data valid
	localparam int FCIC_T_WRITE_NS = 35; // write strobe low width
	localparam int FCIC_SETUP_CYC =
		(FCIC_T_SETUP_NS * FCIC_CLK_MHZ + 999) / 1000;
	localparam int FCIC_READ_CYC =
		(FCIC_T_READ_NS * FCIC_CLK_MHZ + 999) / 1000;
	localparam int FCIC_WRITE_CYC =
		(FCIC_T_WRITE_NS * FCIC_CLK_MHZ + 999) / 1000;
	localparam int FCIC_POLL_MAX = 60000; // status reads before giving up
	// ==========================================================
	// command sequence addresses and data
	localparam logic [18:0] FCIC_UNLOCK1_ADDR = 19'h00555;
	localparam logic [18:0] FCIC_UNLOCK2_ADDR = 19'h002AA;
	localparam logic [7:0] FCIC_UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] FCIC_UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] FCIC_CMD_IDENT = 8'h90;
	localparam logic [7:0] FCIC_CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] FCIC_CMD_RESET = 8'hF0;
	// ==========================================================
	// identification read layout
	localparam logic [15:0] FCIC_PROT_LOW = 16'h0002; // bit1 high, bit0 low
	localparam int FCIC_SECT_MSB = 18; // sector field top bit
	localparam int FCIC_SECT_LSB = 16; // sector field bottom bit
	localparam int FCIC_A6_BIT = 6; // held low for pin identification
	// ==========================================================
	// status bits seen while polling
	localparam int FCIC_POLL_BIT = 7; // complement of data until done
	localparam int FCIC_LIMIT_BIT = 5; // exceeded_limit_flag
	// ==========================================================
	// user operations
	typedef enum logic [2:0] {
		FCIC_OP_READ,
		FCIC_OP_RESET,
		FCIC_OP_ID_ENTER,
		FCIC_OP_PROT,
		FCIC_OP_HV_ID,
		FCIC_OP_PROGRAM
	} fcic_op_t;
endpackage : fcic_pkg

//--- logic/fcic_cycle.sv
// one flash bus cycle: a read or a write on the strobe pins
// assumes the flash pins are synchronous to clk_sys through pad flops
`timescale 1ns/10ps
module fcic_cycle
	import fcic_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start, // one-cycle request
	input wire logic is_write, // write when high, read when low
	input wire logic hv_id, // raise pin identification voltage on a read cycle
	input wire logic [18:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] data_lines_in,
	output logic done, // one-cycle pulse at cycle end
	output logic [7:0] rdata,
	output logic [18:0] flash_addr,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe_n, // low while driving
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic id_hv_en
);
	// ==========================================================
	// state and counters
	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fcic_cst_t;
	fcic_cst_t st_reg; // phase of the cycle
	logic [7:0] cnt_reg; // cycles left in a phase
	logic wr_reg; // current cycle is a write
	wire logic cnt_zero = (cnt_reg == 8'h00);
	wire logic [7:0] strobe_len = wr_reg ? 8'(FCIC_WRITE_CYC - 1)
		: 8'(FCIC_READ_CYC - 1);

	// ==========================================================
	// phase sequencer: address before strobe, data past its rise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= C_IDLE;
			cnt_reg <= 8'h00;
			wr_reg <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			flash_addr <= 19'h00000;
			data_lines_out <= 8'h00;
			data_lines_oe_n <= 1'b1;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			id_hv_en <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_reg)
				C_IDLE: begin
					if (start) begin
						// address, data and select lead the strobe
						wr_reg <= is_write;
						flash_addr <= addr;
						data_lines_out <= wdata;
						data_lines_oe_n <= ~is_write;
						id_hv_en <= hv_id & ~is_write;
						ce_n <= 1'b0;
						cnt_reg <= 8'(FCIC_SETUP_CYC - 1);
						st_reg <= C_SETUP;
					end
				end
				C_SETUP: begin
					if (cnt_zero) begin
						// write keeps gate high, read keeps strobe high
						we_n <= ~wr_reg;
						oe_n <= wr_reg;
						cnt_reg <= strobe_len;
						st_reg <= C_STROBE;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				C_STROBE: begin
					if (cnt_zero) begin
						// data still driven as the strobe rises
						if (!wr_reg) begin
							rdata <= data_lines_in;
						end
						we_n <= 1'b1;
						oe_n <= 1'b1;
						st_reg <= C_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				C_HOLD: begin
					// release select and data after the strobe
					ce_n <= 1'b1;
					data_lines_oe_n <= 1'b1;
					id_hv_en <= 1'b0;
					done <= 1'b1;
					st_reg <= C_IDLE;
				end
				default: begin
					st_reg <= C_IDLE;
				end
			endcase
		end
	end
endmodule : fcic_cycle

//--- logic/fcic_host.sv
// host controller that drives a byte-wide flash through its pins
// assumes one request at a time on the user port, flash pins on clk_sys
//
// How it works
// - protect query: sector, bit1 high, bit0 low
// - pin identification: high voltage, A6 low
// - write needs select, strobe low, gate high
// - exceeded limit: host writes reset command
// - only reset leaves identification mode
// - read: select and gate low, strobe high
// - two unlocks then identification command
`timescale 1ns/10ps
module fcic_host
	import fcic_pkg::*;
#(
	parameter int POLL_MAX = FCIC_POLL_MAX // status reads before abort
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req, // one-cycle request, taken when not busy
	input wire logic [2:0] op, // fcic_op_t code
	input wire logic [18:0] addr,
	input wire logic [7:0] wdata,
	output logic busy,
	output logic ack, // one-cycle pulse at completion
	output logic fail, // program ended on exceeded limit or timeout
	output logic [7:0] rdata,
	output logic [2:0] sector_address, // sector of the last request
	output logic prot_flag, // low bit of the last protect query
	output logic [18:0] flash_addr,
	input wire logic [7:0] data_lines_in,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe_n,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic id_hv_en // identification_high_voltage on bit nine
);
	// ==========================================================
	// control state
	typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT} fcic_mst_t;
	fcic_mst_t st_reg; // controller phase
	fcic_op_t op_reg; // operation in progress
	logic [2:0] step_reg; // bus cycle index in the sequence
	logic [18:0] addr_reg; // user address
	logic [7:0] wdata_reg; // user data
	logic limit_seen_reg; // exceeded_limit_flag seen once
	logic [15:0] poll_reg; // status reads done
	logic cyc_start_reg; // launches one bus cycle
	logic cyc_done; // bus cycle finished
	logic [7:0] cyc_rdata; // byte of that cycle

	// ==========================================================
	// per-step cycle decode
	logic step_wr; // this step writes
	logic step_hv; // this step uses the pin method
	logic [18:0] step_addr;
	logic [7:0] step_data;
	logic [2:0] step_last; // index of final fixed step
	wire logic [2:0] sect = addr_reg[FCIC_SECT_MSB:FCIC_SECT_LSB];
	wire logic [18:0] hv_addr = {addr_reg[18:FCIC_A6_BIT + 1], 1'b0,
		addr_reg[FCIC_A6_BIT - 1:0]};

	// sequence table of addresses and data for each operation
	always_comb begin
		step_wr = 1'b0;
		step_hv = 1'b0;
		step_addr = addr_reg;
		step_data = wdata_reg;
		step_last = 3'h0;
		case (op_reg)
			FCIC_OP_READ: begin
				// plain array read, no command needed
				step_addr = addr_reg;
			end
			FCIC_OP_RESET: begin
				// any address will do
				step_wr = 1'b1;
				step_data = FCIC_CMD_RESET;
			end
			FCIC_OP_ID_ENTER: begin
				// two unlocks then the identification command
				step_wr = 1'b1;
				step_last = 3'h2;
				step_addr = (step_reg == 3'h1) ? FCIC_UNLOCK2_ADDR
					: FCIC_UNLOCK1_ADDR;
				step_data = (step_reg == 3'h0) ? FCIC_UNLOCK1_DATA
					: (step_reg == 3'h1) ? FCIC_UNLOCK2_DATA
					: FCIC_CMD_IDENT;
			end
			FCIC_OP_PROT: begin
				// sector on top bits, bit1 high, bit0 low
				step_addr = {sect, FCIC_PROT_LOW};
			end
			FCIC_OP_HV_ID: begin
				// caller picks the code with address bits 1 and 0
				step_hv = 1'b1;
				step_addr = hv_addr;
			end
			FCIC_OP_PROGRAM: begin
				// four writes in order, then status reads
				step_last = 3'h4;
				step_wr = (step_reg != 3'h4);
				case (step_reg)
					3'h0: begin
						step_addr = FCIC_UNLOCK1_ADDR;
						step_data = FCIC_UNLOCK1_DATA;
					end
					3'h1: begin
						step_addr = FCIC_UNLOCK2_ADDR;
						step_data = FCIC_UNLOCK2_DATA;
					end
					3'h2: begin
						step_addr = FCIC_UNLOCK1_ADDR;
						step_data = FCIC_CMD_PROGRAM;
					end
					3'h5: begin
						// recovery write after an exceeded limit
						step_wr = 1'b1;
						step_data = FCIC_CMD_RESET;
					end
					default: begin
						step_addr = addr_reg;
						step_data = wdata_reg;
					end
				endcase
			end
			default: begin
				step_addr = addr_reg;
			end
		endcase
	end

	// ==========================================================
	// polling decisions after a status read
	wire logic poll_step = (op_reg == FCIC_OP_PROGRAM)
		&& (step_reg == 3'h4);
	wire logic reset_step = (op_reg == FCIC_OP_PROGRAM)
		&& (step_reg == 3'h5);
	wire logic poll_ok = (cyc_rdata[FCIC_POLL_BIT]
		== wdata_reg[FCIC_POLL_BIT]);
	wire logic poll_limit = cyc_rdata[FCIC_LIMIT_BIT];
	wire logic poll_timeout = (poll_reg == 16'(POLL_MAX - 1));
	// a second read confirms the limit before giving up
	wire logic poll_abort = ~poll_ok & ((poll_limit & limit_seen_reg)
		| poll_timeout);
	wire logic seq_end = reset_step | (~poll_step & (step_reg == step_last))
		| (poll_step & poll_ok);

	// ==========================================================
	// controller sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= M_IDLE;
			op_reg <= FCIC_OP_READ;
			step_reg <= 3'h0;
			addr_reg <= 19'h00000;
			wdata_reg <= 8'h00;
			limit_seen_reg <= 1'b0;
			poll_reg <= 16'h0000;
			cyc_start_reg <= 1'b0;
			busy <= 1'b0;
			ack <= 1'b0;
			fail <= 1'b0;
			rdata <= 8'h00;
			sector_address <= 3'h0;
			prot_flag <= 1'b0;
		end else begin
			ack <= 1'b0;
			cyc_start_reg <= 1'b0;
			case (st_reg)
				M_IDLE: begin
					if (req) begin
						// take the request and start at step zero
						op_reg <= fcic_op_t'(op);
						addr_reg <= addr;
						wdata_reg <= wdata;
						sector_address <= addr[FCIC_SECT_MSB:FCIC_SECT_LSB];
						step_reg <= 3'h0;
						limit_seen_reg <= 1'b0;
						poll_reg <= 16'h0000;
						fail <= 1'b0;
						busy <= 1'b1;
						st_reg <= M_ISSUE;
					end
				end
				M_ISSUE: begin
					cyc_start_reg <= 1'b1;
					st_reg <= M_WAIT;
				end
				M_WAIT: begin
					if (cyc_done) begin
						rdata <= cyc_rdata;
						if (op_reg == FCIC_OP_PROT) begin
							prot_flag <= cyc_rdata[0];
						end
						if (seq_end) begin
							// last cycle of the sequence: drop busy and pulse ack
							busy <= 1'b0;
							ack <= 1'b1;
							st_reg <= M_IDLE;
						end else if (poll_step & poll_abort) begin
							// reset command written while still busy; busy drops and ack pulses after it
							fail <= 1'b1;
							step_reg <= 3'h5;
							st_reg <= M_ISSUE;
						end else if (poll_step) begin
							// read status again
							limit_seen_reg <= limit_seen_reg | poll_limit;
							poll_reg <= poll_reg + 16'h0001;
							st_reg <= M_ISSUE;
						end else begin
							step_reg <= step_reg + 3'h1;
							st_reg <= M_ISSUE;
						end
					end
				end
				default: begin
					st_reg <= M_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// pin cycle engine
	fcic_cycle u_cycle (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(cyc_start_reg),
		.is_write(step_wr),
		.hv_id(step_hv),
		.addr(step_addr),
		.wdata(step_data),
		.data_lines_in(data_lines_in),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_addr(flash_addr),
		.data_lines_out(data_lines_out),
		.data_lines_oe_n(data_lines_oe_n),
		.ce_n(ce_n),
		.oe_n(oe_n),
		.we_n(we_n),
		.id_hv_en(id_hv_en)
	);
endmodule : fcic_host

//--- sim/fcic_host_monitor.sv
// assertions on the host controller ports
// assumes one clk_sys domain, bound onto fcic_host
`timescale 1ns/10ps
module fcic_host_monitor
	import fcic_pkg::*;
#(
	parameter int POLL_MAX = FCIC_POLL_MAX // same as the controller
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req,
	input wire logic [2:0] op,
	input wire logic [18:0] addr,
	input wire logic busy,
	input wire logic ack,
	input wire logic fail,
	input wire logic [2:0] sector_address,
	input wire logic [18:0] flash_addr,
	input wire logic [7:0] data_lines_out,
	input wire logic data_lines_oe_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic id_hv_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// =====
	// op of the request in flight
	logic [2:0] op_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			op_reg <= 3'h0;
		else if (req && !busy)
			op_reg <= op;
	end
	// sector field kept from the taking edge
	property p_sect;
		logic [2:0] s;
		(req && !busy, s = addr[18:16]) |=> sector_address == s;
	endproperty
	// =====
	// pin and port relations
	a_gate_floats: assert property (!data_lines_oe_n |-> oe_n)
		else $error("data driven while gate low");
	a_write_strobe: assert property (!we_n |-> !ce_n && oe_n)
		else $error("write strobe without select or with gate");
	a_read_strobe: assert property (!oe_n |-> !ce_n && we_n)
		else $error("read gate without select or with strobe");
	a_hv_a6_low: assert property (id_hv_en && !ce_n |-> !flash_addr[6])
		else $error("bit six high under high voltage");
	a_addr_held: assert property (!we_n |-> $stable(flash_addr))
		else $error("address moved during write strobe");
	a_data_held: assert property ($rose(we_n) |->
		!data_lines_oe_n && $stable(data_lines_out))
		else $error("data not held past strobe rise");
	a_sector_take: assert property (p_sect)
		else $error("sector field not taken");
	a_prot_query: assert property (op_reg == FCIC_OP_PROT && busy
		&& !oe_n |-> flash_addr[15:0] == FCIC_PROT_LOW
		&& flash_addr[18:16] == sector_address)
		else $error("protect query address wrong");
	a_reset_cmd: assert property (op_reg == FCIC_OP_RESET && busy
		&& $rose(we_n) |-> data_lines_out == FCIC_CMD_RESET)
		else $error("reset op wrote wrong byte");
	// main scenarios reached
	c_prot: cover property (ack && op_reg == FCIC_OP_PROT);
	c_fail: cover property ($rose(fail));
	c_hv: cover property (id_hv_en && !oe_n);
endmodule : fcic_host_monitor

bind fcic_host fcic_host_monitor #(.POLL_MAX(POLL_MAX)) u_mon (
	.clk_sys(clk_sys),
	.rst(rst),
	.req(req),
	.op(op),
	.addr(addr),
	.busy(busy),
	.ack(ack),
	.fail(fail),
	.sector_address(sector_address),
	.flash_addr(flash_addr),
	.data_lines_out(data_lines_out),
	.data_lines_oe_n(data_lines_oe_n),
	.ce_n(ce_n),
	.oe_n(oe_n),
	.we_n(we_n),
	.id_hv_en(id_hv_en)
);

//--- sim/fcic_flash_model.sv
// behavioural byte-wide flash facing the host controller pins
// assumes strobes move on clk_sys edges; program time in clk_sys cycles
`timescale 1ns/10ps
module fcic_flash_model
	import fcic_pkg::*;
#(
	parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
	parameter logic [7:0] PART = 8'hC3, // arbitrary value
	parameter logic [7:0] PROT = 8'h00, // all unprotected
	parameter int BUSY_CYC = 40 // program time
)(
	input wire logic clk_sys,
	input wire logic stuck, // program hangs with limit flag up
	input wire logic low_supply, // below supply_lockout_threshold
	input wire logic [18:0] flash_addr,
	input wire logic [7:0] dq_bus, // resolved data lines
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic id_hv_en,
	output logic [7:0] dq_out
);
	logic [7:0] mem [logic [18:0]]; // written bytes, rest erased
	logic [18:0] a_lat; // latched address
	logic [18:0] p_addr; // program target
	logic [7:0] p_data; // program data
	logic u1; // first unlock address seen
	logic armed = 1'b0; // a real strobe fall since power-up
	int st = 0; // array read from power-up
	int bcnt = 0; // program cycles left
	initial dq_out = 8'h00;
	// identification byte for an address
	function automatic logic [7:0] id_code(input logic [18:0] a);
		case (a[1:0])
		2'h0: return MAKER;
		2'h1: return PART;
		2'h2: return {7'h0, PROT[a[18:16]]};
		default: return 8'h00;
		endcase
	endfunction : id_code
	// =====
	// address latch on the later falling strobe
	always @(negedge we_n) begin
		a_lat = flash_addr;
		// a strobe already low at power-up never arms a command
		armed = ($time > 0);
	end
	// command decode on the earlier rising strobe
	always @(posedge we_n) begin
		u1 = (a_lat == FCIC_UNLOCK1_ADDR);
		if (!low_supply && armed && !ce_n && oe_n) begin
			if (bcnt > 0)
				bcnt = (stuck && dq_bus == FCIC_CMD_RESET) ? 0 : bcnt;
			else if (dq_bus == FCIC_CMD_RESET)
				st = 0;
			else
				case (st)
				0: st = (u1 && dq_bus == FCIC_UNLOCK1_DATA) ? 1 : 0;
				1: st = (dq_bus == FCIC_UNLOCK2_DATA) ? 2 : 0;
				2: st = !u1 ? 0 : (dq_bus == FCIC_CMD_IDENT) ? 4 :
					(dq_bus == FCIC_CMD_PROGRAM) ? 3 : 0;
				3: begin
					if (!PROT[a_lat[18:16]]) begin
						p_addr = a_lat;
						p_data = dq_bus;
						bcnt = BUSY_CYC;
					end
					st = 0;
				end
				4: st = 4;
				default: st = 0;
				endcase
		end
	end
	// program timer and read path
	always @(posedge clk_sys) begin
		if (low_supply) begin
			// below the lockout threshold the device resets itself
			st = 0;
			bcnt = 0;
		end
		if (bcnt > 0 && !stuck) begin
			if (bcnt == 1)
				mem[p_addr] = p_data;
			bcnt = bcnt - 1;
		end
		if (ce_n || oe_n || !we_n)
			dq_out <= ~dq_out; // not being read: output toggles every clock
		else if ((id_hv_en && !flash_addr[6]) || st == 4)
			dq_out <= id_code(flash_addr);
		else if (bcnt > 0)
			dq_out <= {~p_data[7], 1'h0, stuck, 5'h0};
		else
			dq_out <= mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF;
	end
endmodule : fcic_flash_model

//--- sim/tb.sv
// self-checking bench: host controller against the flash model
// assumes the monitor is bound by its own file
`timescale 1ns/10ps
module tb
	import fcic_pkg::*;
;
	localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
	localparam logic [7:0] PART = 8'hC3; // arbitrary value
	typedef struct {
		logic [2:0] op;
		logic [18:0] a;
		logic [7:0] d;
		logic [7:0] rd;
		logic chk;
		logic fl;
	} fcic_row_t;
	logic clk_sys, rst, req, stuck, busy, ack, fail, prot_flag, low_supply;
	logic [2:0] op, sector_address;
	logic [18:0] addr, flash_addr;
	logic [7:0] wdata, rdata, data_lines_out, dq_out, dl_in;
	logic data_lines_oe_n, ce_n, oe_n, we_n, id_hv_en;
	int num_errors = 0;
	int samples_checked = 0;
	fcic_row_t rows [16] = '{
		'{FCIC_OP_READ, 19'h12345, 8'h00, 8'hFF, 1'b1, 1'b0},
		'{FCIC_OP_PROGRAM, 19'h12345, 8'h5A, 8'h00, 1'b0, 1'b0},
		'{FCIC_OP_READ, 19'h12345, 8'h00, 8'h5A, 1'b1, 1'b0},
		'{FCIC_OP_ID_ENTER, 19'h00000, 8'h00, 8'h00, 1'b0, 1'b0},
		'{FCIC_OP_READ, 19'h00000, 8'h00, MAKER, 1'b1, 1'b0},
		'{FCIC_OP_READ, 19'h00001, 8'h00, PART, 1'b1, 1'b0},
		'{FCIC_OP_PROT, 19'h50002, 8'h00, 8'h01, 1'b1, 1'b0},
		'{FCIC_OP_PROT, 19'h20002, 8'h00, 8'h00, 1'b1, 1'b0},
		'{FCIC_OP_READ, 19'h00000, 8'h00, MAKER, 1'b1, 1'b0},
		'{FCIC_OP_RESET, 19'h7ABCD, 8'h00, 8'h00, 1'b0, 1'b0},
		'{FCIC_OP_READ, 19'h12345, 8'h00, 8'h5A, 1'b1, 1'b0},
		'{3'h7, 19'h12345, 8'h00, 8'h5A, 1'b1, 1'b0},
		'{FCIC_OP_PROGRAM, 19'h50010, 8'h00, 8'h00, 1'b0, 1'b1},
		'{FCIC_OP_READ, 19'h50010, 8'h00, 8'hFF, 1'b1, 1'b0},
		'{FCIC_OP_HV_ID, 19'h00040, 8'h00, MAKER, 1'b1, 1'b0},
		'{FCIC_OP_HV_ID, 19'h00041, 8'h00, PART, 1'b1, 1'b0}
	};
	// host drives the lines only with its enable low
	assign dl_in = data_lines_oe_n ? dq_out : data_lines_out;
	always #5 clk_sys = ~clk_sys;
	fcic_host #(.POLL_MAX(8)) dut (.clk_sys(clk_sys), .rst(rst),
		.req(req), .op(op), .addr(addr), .wdata(wdata), .busy(busy),
		.ack(ack), .fail(fail), .rdata(rdata),
		.sector_address(sector_address), .prot_flag(prot_flag),
		.flash_addr(flash_addr), .data_lines_in(dl_in),
		.data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .id_hv_en(id_hv_en));
	fcic_flash_model #(.MAKER(MAKER), .PART(PART), .PROT(8'h20)) u_flash (
		.clk_sys(clk_sys), .stuck(stuck), .low_supply(low_supply),
		.flash_addr(flash_addr),
		.dq_bus(dl_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.id_hv_en(id_hv_en), .dq_out(dq_out));
	// =====
	// compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %0t got %h exp %h", $time, g, e);
			num_errors++;
		end
	endtask : chk
	// one user request, waits for its ack
	task automatic run_op(input logic [2:0] o, input logic [18:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= 1'b1;
		op <= o;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		req <= 1'b0;
		while (ack !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 3000)
			num_errors++;
	endtask : run_op
	// idle levels of the strobes and flags
	function automatic logic [7:0] pins();
		return {busy, ce_n, oe_n, we_n, data_lines_oe_n, id_hv_en, ack, fail};
	endfunction : pins
	task automatic complete_run();
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// =====
	// watchdog
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
	// main sequence
	initial begin
		{clk_sys, req, stuck, low_supply, op, addr, wdata} = '0;
		rst = 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk(pins(), 8'h78);
		foreach (rows[i]) begin
			run_op(rows[i].op, rows[i].a, rows[i].d);
			if (rows[i].chk)
				chk(rdata, rows[i].rd);
			chk({7'h0, fail}, {7'h0, rows[i].fl});
			chk({5'h0, sector_address}, {5'h0, rows[i].a[18:16]});
			if (rows[i].op == FCIC_OP_PROT)
				chk({7'h0, prot_flag}, rows[i].rd);
		end
		// supply below lockout: the unlock sequence has no effect
		low_supply <= 1'b1;
		run_op(FCIC_OP_ID_ENTER, 19'h00000, 8'h00);
		low_supply <= 1'b0;
		run_op(FCIC_OP_READ, 19'h00000, 8'h00);
		chk(rdata, 8'hFF);
		// limit flag during program: abort, then array read again
		stuck <= 1'b1;
		run_op(FCIC_OP_PROGRAM, 19'h30000, 8'h11);
		chk({7'h0, fail}, 8'h01);
		stuck <= 1'b0;
		run_op(FCIC_OP_READ, 19'h30000, 8'h00);
		chk(rdata, 8'hFF);
		// reset in the middle of a read
		@(posedge clk_sys);
		req <= 1'b1;
		addr <= 19'h12345;
		@(posedge clk_sys);
		req <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b1;
		#1;
		chk(pins(), 8'h78);
		@(posedge clk_sys);
		rst <= 1'b0;
		run_op(FCIC_OP_READ, 19'h12345, 8'h00);
		chk(rdata, 8'h5A);
		complete_run();
	end
endmodule : tb
